// ---- verilog/diag_consts.vh ----
`ifndef DIAG_CONSTS_VH
`define DIAG_CONSTS_VH
`define SAT_RUN_LEN        20
`define TICK_DIV           131
`define TICK_CNT_W         8
`define OFFS_LOW           24'h07FFFF
`define OFFS_HIGH          24'hF80000
`define DATA_W             24
`define DATA_ALL_ONES      24'hFFFFFF
`define DATA_ALL_ZEROS     24'h000000
`define PULSE_CNT_W        8
`define REG_ADDR_W         6
`define LAST_USER_ADDR     6'h38
`define FLAG_COUNT         16
`define F_CAL              0
`define F_CONV             1
`define F_SAT              2
`define F_POS_OV           3
`define F_POS_UV           4
`define F_NEG_OV           5
`define F_NEG_UV           6
`define F_AREG             7
`define F_DREG             8
`define F_DECAP            9
`define F_PULSE            10
`define F_RD               11
`define F_WR               12
`define F_IGNORE           13
`define DECAP_NONE         2'h0
`define DECAP_ANALOG       2'h1
`define DECAP_DIGITAL      2'h2
`endif

// ---- verilog/sat_run_detect.v ----
`timescale 1ns/1ns
`default_nettype none
`include "diag_consts.vh"
module sat_run_detect #(
  parameter RUN_LEN = `SAT_RUN_LEN
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       nrst,
  // Modulator bitstream
  input  wire       bit_valid,
  input  wire       bit_value,
  // Result
  output wire       saturated
);
  reg [5:0] run_ff;
  reg       last_ff;
  reg [5:0] nxt_run;

  always @* begin
    nxt_run = run_ff;
    if (bit_valid) begin
      if (bit_value == last_ff && run_ff != 6'h00) begin
        if (run_ff != RUN_LEN[5:0])
          nxt_run = run_ff + 6'h01;
      end else begin
        nxt_run = 6'h01;
      end
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_ff  <= 6'h00;
      last_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      if (bit_valid)
        last_ff <= bit_value;
    end
  end

  // Saturation holds once the run of equal bits reaches its length.
  assign saturated = (run_ff == RUN_LEN[5:0]);
endmodule
`default_nettype wire

// ---- verilog/converter_diagnostic_monitor.v ----
// What this block does
// - Filter overflow flags conversion fault, clamps result
// - Conversion flag updates with data; read clears
// - Twenty equal modulator bits flag saturation
// - Offset coefficient outside range: keep, flag
// - Full-scale overflow: keep gain, flag calibration
// - Calibration, conversion, saturation flags need enables
// - Four input over/under flags, separately enabled
// - Regulator low flags stay until read
// - Trip test grounds monitor input, forcing flag
// - Decap check turns regulator off, watches fall
// - Decap check tests one regulator at once
// - Decap self test disconnects capacitor, forcing fault
// - Tick counter increments every 131 clocks
// - Tick counter wraps to zero at maximum
// - Pulse count not multiple of eight flags
// - Bad-count write aborted, register unchanged
// - Undefined address flags read/write error, aborts
// - Loading or calibrating: flag ignore, drop writes
// - Write-ignore check enabled after reset
// - Any error flag sets summary status bit
`timescale 1ns/1ns
`default_nettype none
`include "diag_consts.vh"
module converter_diagnostic_monitor #(
  parameter DATA_W  = `DATA_W,
  parameter TICK_W  = `TICK_CNT_W,
  parameter TICK_DIV = `TICK_DIV
) (
  // Clock and reset
  input  wire              ref_clk,
  input  wire              nrst,
  // Error enables
  input  wire              cal_fault_enable,
  input  wire              conversion_fault_enable,
  input  wire              saturation_fault_enable,
  input  wire              pos_input_over_enable,
  input  wire              pos_input_under_enable,
  input  wire              neg_input_over_enable,
  input  wire              neg_input_under_enable,
  input  wire              analog_reg_monitor_enable,
  input  wire              digital_reg_monitor_enable,
  input  wire              analog_reg_trip_test,
  input  wire              digital_reg_trip_test,
  input  wire [1:0]        decap_check_select,
  input  wire              decap_check_self_test,
  input  wire              clock_tick_count_enable,
  input  wire              serial_pulse_count_enable,
  input  wire              read_addr_check_enable,
  input  wire              write_addr_check_enable,
  input  wire              write_ignore_disable,
  // Conversion path
  input  wire              result_valid,
  input  wire [DATA_W-1:0] result_raw,
  input  wire              filter_overflow,
  input  wire              filter_underflow,
  input  wire              mod_bit_valid,
  input  wire              mod_bit,
  // Calibration path
  input  wire              offset_cal_done,
  input  wire [DATA_W-1:0] offset_cal_coeff,
  input  wire              gain_cal_done,
  input  wire [DATA_W-1:0] gain_cal_coeff,
  input  wire              cal_busy,
  input  wire              defaults_loading,
  // Analog comparators, asynchronous
  input  wire              pos_over_cmp,
  input  wire              pos_under_cmp,
  input  wire              neg_over_cmp,
  input  wire              neg_under_cmp,
  input  wire              analog_reg_below_cmp,
  input  wire              digital_reg_below_cmp,
  input  wire              decap_falling_cmp,
  // Serial interface pins
  input  wire              cs_n,
  input  wire              sclk,
  // Decoded transaction from serial front end
  input  wire              addr_valid,
  input  wire              addr_is_write,
  input  wire [5:0]        reg_addr,
  input  wire              write_request,
  // Error register read
  input  wire              error_read,
  // Outputs
  output reg  [DATA_W-1:0] data_ff,
  output reg               data_update_ff,
  output reg  [DATA_W-1:0] offset_ff,
  output reg  [DATA_W-1:0] gain_ff,
  output reg  [TICK_W-1:0] tick_count_ff,
  output reg  [15:0]       error_flags_ff,
  output reg               summary_error_ff,
  output wire              write_commit,
  output wire              access_abort,
  output wire              analog_reg_off,
  output wire              digital_reg_off,
  output wire              analog_monitor_grounded,
  output wire              digital_monitor_grounded,
  output wire              decap_disconnect
);
  // Pin synchronisers: the first stage feeds only the second.
  reg [6:0] cmp_s1_ff;
  reg [6:0] cmp_s2_ff;
  reg       cs_s1_ff;
  reg       cs_s2_ff;
  reg       cs_d_ff;
  reg       sclk_s1_ff;
  reg       sclk_s2_ff;
  reg       sclk_d_ff;
  reg [7:0] pulse_cnt_ff;
  reg [7:0] tick_div_ff;
  reg       wr_ok_ff;
  reg [15:0] nxt_flags;
  reg [15:0] cond;
  wire       sat_run;
  wire       sclk_rise;
  wire       frame_end;
  wire       pulse_bad;
  wire       addr_bad;
  wire       ignore_now;
  wire       offs_ok;
  wire [3:0] input_en;
  wire [3:0] input_hit;
  genvar     gi;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmp_s1_ff  <= 7'h00;
      cmp_s2_ff  <= 7'h00;
      cs_s1_ff   <= 1'b1;
      cs_s2_ff   <= 1'b1;
      cs_d_ff    <= 1'b1;
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_d_ff  <= 1'b0;
    end else begin
      cmp_s1_ff  <= {decap_falling_cmp, digital_reg_below_cmp,
                     analog_reg_below_cmp, neg_under_cmp, neg_over_cmp,
                     pos_under_cmp, pos_over_cmp};
      cmp_s2_ff  <= cmp_s1_ff;
      cs_s1_ff   <= cs_n;
      cs_s2_ff   <= cs_s1_ff;
      cs_d_ff    <= cs_s2_ff;
      sclk_s1_ff <= sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_d_ff  <= sclk_s2_ff;
    end
  end

  sat_run_detect #(
    .RUN_LEN (`SAT_RUN_LEN)
  ) u_sat (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .bit_valid (mod_bit_valid),
    .bit_value (mod_bit),
    .saturated (sat_run)
  );

  // Self-test controls drive the analog switches directly.
  assign analog_monitor_grounded  = analog_reg_trip_test;
  assign digital_monitor_grounded = digital_reg_trip_test;
  // A select of both regulators is treated as none, so only one is off.
  assign analog_reg_off  = (decap_check_select == `DECAP_ANALOG);
  assign digital_reg_off = (decap_check_select == `DECAP_DIGITAL);
  assign decap_disconnect = decap_check_self_test &&
                            (analog_reg_off || digital_reg_off);

  // Serial pulse counting within a chip select frame.
  assign sclk_rise = sclk_s2_ff && !sclk_d_ff && !cs_s2_ff;
  assign frame_end = cs_s2_ff && !cs_d_ff;
  assign pulse_bad = serial_pulse_count_enable &&
                     (pulse_cnt_ff[2:0] != 3'h0);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt_ff <= 8'h00;
    end else if (cs_s2_ff) begin
      pulse_cnt_ff <= 8'h00;
    end else if (sclk_rise) begin
      pulse_cnt_ff <= pulse_cnt_ff + 8'h01;
    end
  end

  assign addr_bad   = (reg_addr > `LAST_USER_ADDR);
  assign ignore_now = !write_ignore_disable &&
                      (defaults_loading || cal_busy);

  // Address legality is decided at decode and kept until the frame ends.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ok_ff <= 1'b0;
    end else if (addr_valid) begin
      wr_ok_ff <= addr_is_write &&
                  !(write_addr_check_enable && addr_bad);
    end else if (frame_end) begin
      wr_ok_ff <= 1'b0;
    end
  end

  // The write lands only at frame end, after the pulse count is known.
  assign write_commit = write_request && frame_end && wr_ok_ff &&
                        !pulse_bad && !ignore_now;
  assign access_abort = addr_valid && addr_bad &&
                        ((addr_is_write && write_addr_check_enable) ||
                         (!addr_is_write && read_addr_check_enable));

  // Data and calibration registers.
  assign offs_ok = (offset_cal_coeff >= `OFFS_LOW) &&
                   (offset_cal_coeff <= `OFFS_HIGH);

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      data_ff        <= `DATA_ALL_ZEROS;
      data_update_ff <= 1'b0;
      offset_ff      <= `DATA_ALL_ZEROS;
      gain_ff        <= `DATA_ALL_ZEROS;
    end else begin
      data_update_ff <= result_valid;
      if (result_valid) begin
        if (filter_overflow)
          data_ff <= `DATA_ALL_ONES;
        else if (filter_underflow)
          data_ff <= `DATA_ALL_ZEROS;
        else
          data_ff <= result_raw;
      end
      if (offset_cal_done && offs_ok)
        offset_ff <= offset_cal_coeff;
      if (gain_cal_done && !filter_overflow)
        gain_ff <= gain_cal_coeff;
    end
  end

  // Tick counter: every TICK_DIV clocks, wrapping at its width.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_div_ff   <= 8'h00;
      tick_count_ff <= {TICK_W{1'b0}};
    end else if (!clock_tick_count_enable) begin
      tick_div_ff <= 8'h00;
    end else if (tick_div_ff == TICK_DIV[7:0] - 8'h01) begin
      tick_div_ff   <= 8'h00;
      tick_count_ff <= tick_count_ff + {{(TICK_W-1){1'b0}}, 1'b1};
    end else begin
      tick_div_ff <= tick_div_ff + 8'h01;
    end
  end

  // The four input range checks share one shape: enable and synced level.
  assign input_en = {neg_input_under_enable, neg_input_over_enable,
                     pos_input_under_enable, pos_input_over_enable};
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_input
      assign input_hit[gi] = input_en[gi] && cmp_s2_ff[gi];
    end
  endgenerate

  // Set conditions, each gated by its enable.
  always @* begin
    cond = 16'h0000;
    cond[`F_CAL]  = cal_fault_enable &&
                    ((offset_cal_done && !offs_ok) ||
                     (gain_cal_done && filter_overflow));
    cond[`F_CONV] = conversion_fault_enable && result_valid &&
                    (filter_overflow || filter_underflow);
    cond[`F_SAT]  = saturation_fault_enable && sat_run;
    cond[`F_POS_OV] = input_hit[0];
    cond[`F_POS_UV] = input_hit[1];
    cond[`F_NEG_OV] = input_hit[2];
    cond[`F_NEG_UV] = input_hit[3];
    cond[`F_AREG] = analog_reg_monitor_enable &&
                    (cmp_s2_ff[4] || analog_reg_trip_test);
    cond[`F_DREG] = digital_reg_monitor_enable &&
                    (cmp_s2_ff[5] || digital_reg_trip_test);
    cond[`F_DECAP] = (analog_reg_off || digital_reg_off) &&
                     (cmp_s2_ff[6] || decap_check_self_test);
    cond[`F_PULSE] = frame_end && pulse_bad;
    cond[`F_RD] = access_abort && !addr_is_write;
    cond[`F_WR] = access_abort && addr_is_write;
    cond[`F_IGNORE] = ignore_now;
  end

  // A read clears flags, but a set in the same cycle wins.
  always @* begin
    if (error_read)
      nxt_flags = cond;
    else
      nxt_flags = error_flags_ff | cond;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      error_flags_ff   <= 16'h0000;
      summary_error_ff <= 1'b0;
    end else begin
      error_flags_ff   <= nxt_flags;
      summary_error_ff <= |nxt_flags;
    end
  end
endmodule
`default_nettype wire

// ---- verif/diag_checker_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module diag_checker (
  // Clock, reset and watched ports
  input wire logic        ref_clk, nrst, cs_n, write_commit,
  input wire logic        summary_error_ff, analog_reg_trip_test,
  input wire logic        analog_monitor_grounded, analog_reg_off,
  input wire logic        digital_reg_off, decap_disconnect,
  input wire logic        decap_check_self_test, offset_cal_done,
  input wire logic        gain_cal_done, filter_overflow, result_valid,
  input wire logic        data_update_ff, defaults_loading,
  input wire logic        write_ignore_disable, cal_fault_enable,
  input wire logic [1:0]  decap_check_select,
  input wire logic [15:0] error_flags_ff,
  input wire logic [23:0] offset_ff, gain_ff, data_ff, offset_cal_coeff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence bad_offs;
    offset_cal_done && (offset_cal_coeff < 24'h07FFFF ||
      offset_cal_coeff > 24'hF80000);
  endsequence
  sequence good_offs;
    offset_cal_done && offset_cal_coeff >= 24'h07FFFF &&
      offset_cal_coeff <= 24'hF80000;
  endsequence
  sequence clamp_high;
    data_update_ff && data_ff == 24'hFFFFFF;
  endsequence
  summary_or_a:
    assert property (summary_error_ff == (|error_flags_ff))
    else $error("summary bit disagrees with flags");
  trip_ground_a:
    assert property (analog_reg_trip_test |-> analog_monitor_grounded)
    else $error("trip test left monitor input connected");
  decap_one_a:
    assert property (!(analog_reg_off && digital_reg_off))
    else $error("both regulators switched off");
  decap_digital_a:
    assert property (decap_check_select == 2'h2 |->
      digital_reg_off && !analog_reg_off)
    else $error("wrong regulator off for digital check");
  decap_self_a:
    assert property (decap_check_self_test &&
      (decap_check_select[0] ^ decap_check_select[1]) |-> decap_disconnect)
    else $error("self test did not disconnect capacitor");
  offset_keep_a:
    assert property (bad_offs |=> $stable(offset_ff))
    else $error("out of range offset was stored");
  cal_flag_a:
    assert property (bad_offs ##0 cal_fault_enable |=> error_flags_ff[0])
    else $error("calibration flag missing");
  offset_take_a:
    assert property (good_offs |=> offset_ff == $past(offset_cal_coeff))
    else $error("in range offset not stored");
  gain_keep_a:
    assert property (gain_cal_done && filter_overflow |=> $stable(gain_ff))
    else $error("gain stored despite overflow");
  conv_clamp_a:
    assert property (result_valid && filter_overflow |=> clamp_high)
    else $error("overflow result not clamped high");
  ignore_drop_a:
    assert property (write_commit |->
      !(defaults_loading && !write_ignore_disable))
    else $error("write committed while loading");
  commit_after_a:
    assert property (write_commit |-> cs_n && $past(cs_n) && $past(cs_n, 2))
    else $error("write committed before frame end");
endmodule
bind converter_diagnostic_monitor diag_checker u_diag_checker (.*);
`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input  wire logic       ref_clk,
  // Serial pins and decoded transaction
  output var  logic       cs_n, sclk, addr_valid, addr_is_write,
  output var  logic       write_request,
  output var  logic [5:0] reg_addr
);
  initial {cs_n, sclk, addr_valid, addr_is_write, write_request,
    reg_addr} = 11'h400;
  // The serial clock stands still outside frames, as a real host does.
  task automatic frame(input int n, input logic wr, input logic [5:0] a);
    @(negedge ref_clk);
    cs_n = 1'b0;
    write_request = wr;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
    addr_is_write = wr;
    reg_addr = a;
    addr_valid = 1'b1;
    @(negedge ref_clk);
    addr_valid = 1'b0;
    reg_addr = ~a;
    repeat (4) @(negedge ref_clk);
    cs_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    write_request = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/converter_diagnostic_monitor_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module converter_diagnostic_monitor_tb;
  logic ref_clk=0, nrst=0, cal_fault_enable=0, conversion_fault_enable=0,
    saturation_fault_enable=0, pos_input_over_enable=0,
    pos_input_under_enable=0, neg_input_over_enable=0,
    neg_input_under_enable=0, analog_reg_monitor_enable=0,
    digital_reg_monitor_enable=0, analog_reg_trip_test=0,
    digital_reg_trip_test=0, decap_check_self_test=0,
    clock_tick_count_enable=0, serial_pulse_count_enable=0,
    read_addr_check_enable=0, write_addr_check_enable=0,
    write_ignore_disable=0, result_valid=0, filter_overflow=0,
    filter_underflow=0, mod_bit_valid=0, mod_bit=0, offset_cal_done=0,
    gain_cal_done=0, cal_busy=0, defaults_loading=0, pos_over_cmp=0,
    pos_under_cmp=0, neg_over_cmp=0, neg_under_cmp=0, error_read=0,
    analog_reg_below_cmp=0, digital_reg_below_cmp=0, decap_falling_cmp=0;
  logic [1:0]  decap_check_select = 2'h0;
  logic [23:0] result_raw=0, offset_cal_coeff=0, gain_cal_coeff=0, v, eo=0;
  wire cs_n, sclk, addr_valid, addr_is_write, write_request, data_update_ff,
    summary_error_ff, write_commit, access_abort, analog_reg_off,
    digital_reg_off, analog_monitor_grounded, digital_monitor_grounded,
    decap_disconnect;
  wire [5:0]  reg_addr;
  wire [23:0] data_ff, offset_ff, gain_ff;
  wire [7:0]  tick_count_ff;
  wire [15:0] error_flags_ff;
  logic [15:0] mf = 0;
  logic [7:0] q[$];
  int fails=0, n_checks=0, seed=32'h3a3b, ncom=0, c0, nab=0, a0;
  int fn[6] = '{16, 15, 16, 16, 8, 9};
  int fb[6] = '{16, 10, 12, 11, 16, 10};
  int fw[6] = '{1, 1, 1, 0, 0, 0};
  logic [5:0] fa[6] = '{6'h01, 6'h01, 6'h39, 6'h3F, 6'h38, 6'h02};
  logic [23:0] oc[4] = '{24'h07FFFF, 24'h07FFFE, 24'hF80000, 24'hF80001};
  // A short divider keeps the wrap of the tick counter within the run.
  converter_diagnostic_monitor #(.TICK_DIV(7)) u_converter_diagnostic_monitor
    (.*);
  host_model u_host_model (.*);
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (write_commit) ncom++;
  always @(posedge ref_clk) if (access_abort) nab++;
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flags;
    chk({8'h00, error_flags_ff}, {8'h00, mf});
    chk({23'h0, summary_error_ff}, {23'h0, |mf});
  endtask
  // Flags named in keep still have their cause present, so they survive.
  task automatic clr(input logic [15:0] keep = 16'h0);
    error_read = 1;
    cyc(1);
    error_read = 0;
    cyc(1);
    mf = mf & keep;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(80000);
    fails++;
    results;
  end
  initial begin
    cyc(3);
    nrst = 1;
    defaults_loading = 1;
    cyc(3);
    mf[13] = 1;
    chk_flags;
    defaults_loading = 0;
    clr;
    chk_flags;
    {serial_pulse_count_enable, read_addr_check_enable,
      write_addr_check_enable} = 3'h7;
    for (int i = 0; i < 6; i++) begin
      c0 = ncom;
      a0 = nab;
      u_host_model.frame(fn[i], fw[i][0], fa[i]);
      if (fb[i] < 16) mf[fb[i]] = 1'b1;
      chk(24'(ncom - c0), 24'(fw[i] && fb[i] == 16));
      chk(24'(nab - a0), 24'(fb[i] == 11 || fb[i] == 12));
      chk_flags;
      clr;
      chk_flags;
    end
    $display("framing test done");
    cal_busy = 1;
    for (int i = 0; i < 2; i++) begin
      write_ignore_disable = i[0];
      c0 = ncom;
      u_host_model.frame(16, 1'b1, 6'h02);
      mf[13] = !i[0];
      chk(24'(ncom - c0), 24'(i));
      chk_flags;
      cal_busy = 0;
      clr;
      cal_busy = 1;
    end
    cal_busy = 0;
    $display("ignore test done");
    for (int i = 0; i < 5; i++) begin
      v = i < 4 ? oc[i] : 24'h100000 + 24'($random(seed) & 32'h3FFFFF);
      cal_fault_enable = i != 3;
      eo = (v >= 24'h07FFFF && v <= 24'hF80000) ? v : eo;
      offset_cal_coeff = v;
      offset_cal_done = 1;
      cyc(1);
      offset_cal_done = 0;
      cyc(1);
      mf[0] = eo != v && cal_fault_enable;
      chk(offset_ff, eo);
      chk_flags;
      clr;
    end
    gain_cal_coeff = 24'($random(seed));
    for (int i = 0; i < 2; i++) begin
      filter_overflow = i == 0;
      gain_cal_done = 1;
      cyc(1);
      gain_cal_done = 0;
      filter_overflow = 0;
      cyc(1);
      mf[0] = i == 0;
      chk(gain_ff, i ? gain_cal_coeff : 24'h0);
      chk_flags;
      clr;
    end
    $display("calibration test done");
    conversion_fault_enable = 1;
    for (int i = 0; i < 3; i++) begin
      result_raw = 24'($random(seed));
      {filter_overflow, filter_underflow} = 2'(i);
      result_valid = 1;
      cyc(1);
      {result_valid, filter_overflow, filter_underflow} = 3'h0;
      cyc(1);
      mf[1] = i > 0;
      chk(data_ff, i == 0 ? result_raw : i == 2 ? 24'hFFFFFF : 24'h0);
      chk_flags;
      clr;
    end
    saturation_fault_enable = 1;
    mod_bit_valid = 1;
    for (int i = 0; i < 41; i++) begin
      mod_bit = i < 19 || i == 40;
      cyc(1);
      if (i == 19) chk_flags;
    end
    mod_bit_valid = 0;
    mf[2] = 1;
    chk_flags;
    clr;
    $display("conversion test done");
    {pos_input_over_enable, pos_input_under_enable, neg_input_over_enable,
      neg_input_under_enable, analog_reg_monitor_enable,
      digital_reg_monitor_enable} = 6'h3F;
    cyc(4);
    clr;
    for (int i = 0; i < 6; i++) begin
      {pos_over_cmp, pos_under_cmp, neg_over_cmp, neg_under_cmp,
        analog_reg_below_cmp, digital_reg_below_cmp} = 6'h20 >> i;
      cyc(4);
      mf[3 + i] = 1;
      clr(mf);
      chk_flags;
      {pos_over_cmp, pos_under_cmp, neg_over_cmp, neg_under_cmp,
        analog_reg_below_cmp, digital_reg_below_cmp} = 6'h00;
      cyc(4);
      chk_flags;
      clr;
      chk_flags;
    end
    {analog_reg_trip_test, digital_reg_trip_test} = 2'h3;
    cyc(4);
    mf[8:7] = 2'h3;
    chk({analog_monitor_grounded, digital_monitor_grounded}, 24'h3);
    chk_flags;
    {analog_reg_trip_test, digital_reg_trip_test} = 2'h0;
    cyc(4);
    clr;
    for (int i = 1; i < 3; i++) begin
      decap_check_select = 2'(i);
      decap_check_self_test = i == 2;
      decap_falling_cmp = i == 1;
      cyc(4);
      mf[9] = 1;
      chk({analog_reg_off, digital_reg_off}, 24'(3 - i));
      chk({23'h0, decap_disconnect}, 24'(i == 2));
      chk_flags;
      {decap_falling_cmp, decap_check_select, decap_check_self_test} = 4'h0;
      cyc(4);
      clr;
    end
    $display("monitor test done");
    clock_tick_count_enable = 1;
    cyc(9);
    for (int j = 0; j < 4; j++) begin
      q.push_back(tick_count_ff);
      cyc(1);
    end
    // 260 periods later the counter has wrapped and moved on by four.
    cyc(7 * 260 - 4);
    for (int j = 0; j < 4; j++) begin
      chk(tick_count_ff, 24'(8'(q.pop_front() + 8'h04)));
      cyc(1);
    end
    $display("tick test done");
    results;
  end
endmodule
`default_nettype wire
